// File: flash_timing_pkg.sv
// constants, types and helpers shared by the flash timing block
// Behaviour
// - program pulse lasts 8 x (value+1) ticks
// - program reload resets to 16h
// - page erase lasts 4096 x (value+1) ticks
// - page erase and recovery reset to 04h
// - module erase lasts 4096 x (value+1) ticks
// - module erase reload resets to EAh
// - end delay of (value+1) ticks follows program or page erase
// - end delay reload resets to 18h
// - module erase end waits 8 x (value+1)
// - module erase end reload resets to 3Ch
// - recovery of (value+1) ticks between accesses
// - protection word captured at reset, read-only
// - protection alias reads same as primary
// - function word copy readable, sixteen bits
// - code start loaded in reset, gives branch
// - code start bits 8:0 read zero
// - bits 12:9 are inverted boot region
// - code start bits 15:13 read zero
// - tick is clock divided by divisor+1
// - busy flag set while programming or erasing
package flash_timing_pkg;

  localparam int COUNT_W = 21;
  localparam int DIV_W   = 5;
  localparam int REG_W   = 8;
  localparam int WORD_W  = 16;
  localparam int IDX_W   = 4;
  localparam int LEN_W   = 28;

  // reload reset values
  localparam logic [REG_W-1:0] PROG_RST   = 8'h16;
  localparam logic [REG_W-1:0] PERASE_RST = 8'h04;
  localparam logic [REG_W-1:0] MERASE_RST = 8'hEA;
  localparam logic [REG_W-1:0] END_RST    = 8'h18;
  localparam logic [REG_W-1:0] MEND_RST   = 8'h3C;
  localparam logic [REG_W-1:0] RCV_RST    = 8'h04;

  // tick multipliers as shift amounts
  localparam logic [3:0] SHIFT_X1    = 4'h0;
  localparam logic [3:0] SHIFT_X8    = 4'h3;
  localparam logic [3:0] SHIFT_X4096 = 4'hC;

  // register indices on the register port
  localparam logic [IDX_W-1:0] IDX_PROG       = 4'h0;
  localparam logic [IDX_W-1:0] IDX_PERASE     = 4'h1;
  localparam logic [IDX_W-1:0] IDX_MERASE     = 4'h2;
  localparam logic [IDX_W-1:0] IDX_END        = 4'h3;
  localparam logic [IDX_W-1:0] IDX_MEND       = 4'h4;
  localparam logic [IDX_W-1:0] IDX_RCV        = 4'h5;
  localparam logic [IDX_W-1:0] IDX_FUNC       = 4'h6;
  localparam logic [IDX_W-1:0] IDX_PROT       = 4'h7;
  localparam logic [IDX_W-1:0] IDX_PROT_ALIAS = 4'h8;
  localparam logic [IDX_W-1:0] IDX_CODE       = 4'h9;

  // code start displacement layout
  localparam int BOOT_LSB = 0;
  localparam int BOOT_W   = 4;
  localparam int CODE_AREA_START_BITS_LO  = 9;
  localparam int CODE_AREA_START_BITS_HI  = 3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_PROG   = 3'b001,
    ST_PERASE = 3'b010,
    ST_MERASE = 3'b011,
    ST_END    = 3'b100,
    ST_MEND   = 3'b101,
    ST_RECOV  = 3'b110
  } phase_t;

  typedef enum logic [1:0] {
    OP_PROG   = 2'b00,
    OP_PERASE = 2'b01,
    OP_MERASE = 2'b10,
    OP_NONE   = 2'b11
  } op_t;

  // tick count of a phase: (reload + 1) scaled by a power of two
  function automatic logic [COUNT_W-1:0] scaled_count(input logic [REG_W-1:0] v,
                                                       input logic [3:0]       sh);
    logic [COUNT_W-1:0] n;
    n = COUNT_W'(v) + COUNT_W'(1);
    scaled_count = n << sh;
  endfunction : scaled_count

endpackage : flash_timing_pkg

// File: phase_timer_if.sv
// carrier between the phase sequencer and its down-counter
`timescale 1ns/1ps
interface phase_timer_if;
  import flash_timing_pkg::*;
  logic               load;
  logic [COUNT_W-1:0] count;
  logic [DIV_W-1:0]   divisor;
  logic               done;
  modport seq   (output load, output count, output divisor, input done);
  modport timer (input load, input count, input divisor, output done);
endinterface : phase_timer_if

// File: phase_timer.sv
// prescaled down-counter that times one phase
`timescale 1ns/1ps
module phase_timer
  import flash_timing_pkg::*;
(
  // clock and reset
  input  logic   clk,
  input  logic   rst_n,
  // phase control
  phase_timer_if.timer t
);
  import flash_timing_pkg::*;

  logic [COUNT_W-1:0] cnt;
  logic [COUNT_W-1:0] next_cnt;
  logic [DIV_W-1:0]   pre;
  logic [DIV_W-1:0]   next_pre;
  logic               run;
  logic               next_run;
  logic               tick;

  assign tick   = run && (pre == t.divisor);
  assign t.done = tick && (cnt == COUNT_W'(1));

  always_comb begin
    next_cnt = cnt;
    next_pre = pre;
    next_run = run;
    if (t.load) begin
      next_cnt = t.count;
      next_pre = '0;
      next_run = (t.count != '0);
    end else if (run) begin
      if (tick) begin
        next_pre = '0;
        next_cnt = cnt - COUNT_W'(1);
        if (cnt == COUNT_W'(1)) begin
          next_run = 1'b0;
        end
      end else begin
        next_pre = pre + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      pre <= '0;
      run <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pre <= next_pre;
      run <= next_run;
    end
  end

  a_count_steps_down: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !t.load) |=> (cnt == $past(cnt) - COUNT_W'(1)))
    else $error("phase counter did not step down by one on a tick");

endmodule : phase_timer

// File: flash_timing_and_autoread_regs.sv
// flash timing reload registers, phase sequencer and auto-read words
`timescale 1ns/1ps
module flash_timing_and_autoread_regs
  import flash_timing_pkg::*;
(
  // clock and reset
  input  logic                              clk,
  input  logic                              rstn,
  // register port from the cpu bus master
  input  logic [flash_timing_pkg::IDX_W-1:0]  reg_index,
  input  logic                              reg_wr,
  input  logic                              reg_rd,
  input  logic [flash_timing_pkg::WORD_W-1:0] reg_wdata,
  output logic [flash_timing_pkg::WORD_W-1:0] reg_rdata,
  // flash operation requests
  input  logic                              op_start,
  input  flash_timing_pkg::op_t             op_kind,
  input  logic                              access_req,
  input  logic [flash_timing_pkg::DIV_W-1:0]  prescale_divisor,
  // information block words, sampled after reset
  input  logic [flash_timing_pkg::WORD_W-1:0] info_function_word,
  input  logic [flash_timing_pkg::WORD_W-1:0] info_protection_word,
  // flash array strobes and status
  output logic                              flash_busy_flag,
  output logic                              program_pulse,
  output logic                              page_erase_pulse,
  output logic                              module_erase_pulse,
  output logic                              access_grant,
  output logic [flash_timing_pkg::WORD_W-1:0] code_start_displacement
);
  import flash_timing_pkg::*;

  // reset release through two flip-flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // reload registers
  logic [REG_W-1:0] program_pulse_reload;
  logic [REG_W-1:0] page_erase_pulse_reload;
  logic [REG_W-1:0] module_erase_pulse_reload;
  logic [REG_W-1:0] end_delay_reload;
  logic [REG_W-1:0] module_erase_end_reload;
  logic [REG_W-1:0] recovery_delay_reload;
  logic [REG_W-1:0] next_prog;
  logic [REG_W-1:0] next_perase;
  logic [REG_W-1:0] next_merase;
  logic [REG_W-1:0] next_end;
  logic [REG_W-1:0] next_mend;
  logic [REG_W-1:0] next_rcv;

  // writes are taken any time; software avoids busy periods
  always_comb begin
    next_prog   = program_pulse_reload;
    next_perase = page_erase_pulse_reload;
    next_merase = module_erase_pulse_reload;
    next_end    = end_delay_reload;
    next_mend   = module_erase_end_reload;
    next_rcv    = recovery_delay_reload;
    if (reg_wr) begin
      case (reg_index)
        IDX_PROG:   next_prog   = reg_wdata[REG_W-1:0];
        IDX_PERASE: next_perase = reg_wdata[REG_W-1:0];
        IDX_MERASE: next_merase = reg_wdata[REG_W-1:0];
        IDX_END:    next_end    = reg_wdata[REG_W-1:0];
        IDX_MEND:   next_mend   = reg_wdata[REG_W-1:0];
        IDX_RCV:    next_rcv    = reg_wdata[REG_W-1:0];
        default:    next_prog   = program_pulse_reload;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_pulse_reload      <= PROG_RST;
      page_erase_pulse_reload   <= PERASE_RST;
      module_erase_pulse_reload <= MERASE_RST;
      end_delay_reload          <= END_RST;
      module_erase_end_reload   <= MEND_RST;
      recovery_delay_reload     <= RCV_RST;
    end else begin
      program_pulse_reload      <= next_prog;
      page_erase_pulse_reload   <= next_perase;
      module_erase_pulse_reload <= next_merase;
      end_delay_reload          <= next_end;
      module_erase_end_reload   <= next_mend;
      recovery_delay_reload     <= next_rcv;
    end
  end

  // auto-read words, caught on the first edge after reset release
  logic              cap_done;
  logic              next_cap_done;
  logic [WORD_W-1:0] function_word_copy;
  logic [WORD_W-1:0] protection_word_copy;
  logic [WORD_W-1:0] next_func;
  logic [WORD_W-1:0] next_prot;
  logic [WORD_W-1:0] next_code;
  logic [BOOT_W-1:0] boot_region_select;

  assign boot_region_select = info_protection_word[BOOT_LSB +: BOOT_W];

  // capture once; no write path afterwards
  always_comb begin
    next_cap_done = 1'b1;
    next_func     = function_word_copy;
    next_prot     = protection_word_copy;
    next_code     = code_start_displacement;
    if (!cap_done) begin
      next_func = info_function_word;
      next_prot = info_protection_word;
      next_code = {{CODE_AREA_START_BITS_HI{1'b0}}, ~boot_region_select, {CODE_AREA_START_BITS_LO{1'b0}}};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_done                <= 1'b0;
      function_word_copy      <= '0;
      protection_word_copy    <= '0;
      code_start_displacement <= '0;
    end else begin
      cap_done                <= next_cap_done;
      function_word_copy      <= next_func;
      protection_word_copy    <= next_prot;
      code_start_displacement <= next_code;
    end
  end

  // register read, one cycle after the strobe
  logic [WORD_W-1:0] next_rdata;
  always_comb begin
    next_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_index)
        IDX_PROG:       next_rdata = WORD_W'(program_pulse_reload);
        IDX_PERASE:     next_rdata = WORD_W'(page_erase_pulse_reload);
        IDX_MERASE:     next_rdata = WORD_W'(module_erase_pulse_reload);
        IDX_END:        next_rdata = WORD_W'(end_delay_reload);
        IDX_MEND:       next_rdata = WORD_W'(module_erase_end_reload);
        IDX_RCV:        next_rdata = WORD_W'(recovery_delay_reload);
        IDX_FUNC:       next_rdata = function_word_copy;
        IDX_PROT,
        IDX_PROT_ALIAS: next_rdata = protection_word_copy;
        IDX_CODE:       next_rdata = code_start_displacement;
        default:        next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // phase sequencer
  phase_timer_if tif ();
  phase_t state;
  phase_t next_state;
  logic   next_busy;
  logic   next_grant;

  phase_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .t     (tif.timer)
  );

  assign tif.divisor = prescale_divisor;
  assign tif.load    = (next_state != state) && (next_state != ST_IDLE);

  // a new operation waits until the captured words are in place
  always_comb begin
    next_state = state;
    next_grant = 1'b0;
    case (state)
      ST_IDLE: begin
        if (op_start && cap_done && op_kind == OP_PROG) begin
          next_state = ST_PROG;
        end else if (op_start && cap_done && op_kind == OP_PERASE) begin
          next_state = ST_PERASE;
        end else if (op_start && cap_done && op_kind == OP_MERASE) begin
          next_state = ST_MERASE;
        end else if (access_req && cap_done) begin
          next_grant = 1'b1;
          next_state = ST_RECOV;
        end
      end
      // end delay after program or page erase
      ST_PROG, ST_PERASE: begin
        if (tif.done) next_state = ST_END;
      end
      // longer end delay after module erase
      ST_MERASE: begin
        if (tif.done) next_state = ST_MEND;
      end
      ST_END, ST_MEND: begin
        if (tif.done) next_state = ST_RECOV;
      end
      ST_RECOV: begin
        if (tif.done) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_comb begin
    case (next_state)
      ST_PROG:   tif.count = scaled_count(program_pulse_reload, SHIFT_X8);
      ST_PERASE: tif.count = scaled_count(page_erase_pulse_reload, SHIFT_X4096);
      ST_MERASE: tif.count = scaled_count(module_erase_pulse_reload, SHIFT_X4096);
      ST_END:    tif.count = scaled_count(end_delay_reload, SHIFT_X1);
      ST_MEND:   tif.count = scaled_count(module_erase_end_reload, SHIFT_X8);
      ST_RECOV:  tif.count = scaled_count(recovery_delay_reload, SHIFT_X1);
      default:   tif.count = '0;
    endcase
  end

  // busy through pulse and end delay
  assign next_busy = (next_state != ST_IDLE) && (next_state != ST_RECOV);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state              <= ST_IDLE;
      flash_busy_flag    <= 1'b0;
      program_pulse      <= 1'b0;
      page_erase_pulse   <= 1'b0;
      module_erase_pulse <= 1'b0;
      access_grant       <= 1'b0;
    end else begin
      state              <= next_state;
      flash_busy_flag    <= next_busy;
      program_pulse      <= (next_state == ST_PROG);
      page_erase_pulse   <= (next_state == ST_PERASE);
      module_erase_pulse <= (next_state == ST_MERASE);
      access_grant       <= next_grant;
    end
  end

  // checking helpers: cycles spent in the current phase
  logic [LEN_W-1:0] plen;
  logic [LEN_W-1:0] tick_len;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      plen <= '0;
    end else if (next_state != state) begin
      plen <= '0;
    end else begin
      plen <= plen + LEN_W'(1);
    end
  end
  assign tick_len = LEN_W'(prescale_divisor) + LEN_W'(1);

  // recovery reload as loaded into the timer; software may rewrite it while not busy
  logic [REG_W-1:0] rcv_start;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcv_start <= '0;
    end else if (next_state == ST_RECOV && state != ST_RECOV) begin
      rcv_start <= recovery_delay_reload;
    end
  end

  a_reset_prog_value: assert property (@(posedge clk) disable iff (!rst_n)
    !cap_done |-> program_pulse_reload == PROG_RST)
    else $error("program reload not 16h after reset");
  a_reset_other_values: assert property (@(posedge clk) disable iff (!rst_n)
    !cap_done |-> (page_erase_pulse_reload == PERASE_RST && recovery_delay_reload == RCV_RST
                   && module_erase_pulse_reload == MERASE_RST && end_delay_reload == END_RST
                   && module_erase_end_reload == MEND_RST))
    else $error("a reload register has the wrong reset value");
  a_prog_width: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_PROG && tif.done) |->
      plen + LEN_W'(1) == (LEN_W'(program_pulse_reload) + LEN_W'(1)) * (tick_len << 3))
    else $error("program pulse length wrong");
  a_page_erase_width: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_PERASE && tif.done) |->
      plen + LEN_W'(1) == (LEN_W'(page_erase_pulse_reload) + LEN_W'(1)) * (tick_len << 12))
    else $error("page erase pulse length wrong");
  a_module_erase_width: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_MERASE && tif.done) |->
      plen + LEN_W'(1) == (LEN_W'(module_erase_pulse_reload) + LEN_W'(1)) * (tick_len << 12))
    else $error("module erase pulse length wrong");
  a_end_delay_len: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_END && tif.done) |->
      plen + LEN_W'(1) == (LEN_W'(end_delay_reload) + LEN_W'(1)) * tick_len)
    else $error("end delay length wrong");
  a_mend_delay_len: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_MEND && tif.done) |->
      plen + LEN_W'(1) == (LEN_W'(module_erase_end_reload) + LEN_W'(1)) * (tick_len << 3))
    else $error("module erase end delay length wrong");
  a_recovery_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_RECOV && tif.done) |->
      plen + LEN_W'(1) == (LEN_W'(rcv_start) + LEN_W'(1)) * tick_len)
    else $error("recovery delay length wrong");
  a_busy_in_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    (program_pulse || page_erase_pulse || module_erase_pulse) |-> flash_busy_flag)
    else $error("busy flag low during a pulse");
  a_code_start_boot: assert property (@(posedge clk) disable iff (!rst_n)
    cap_done |-> code_start_displacement[CODE_AREA_START_BITS_LO +: BOOT_W]
                 == ~protection_word_copy[BOOT_LSB +: BOOT_W])
    else $error("code start bits 12:9 not inverted boot region");
  a_code_start_zero: assert property (@(posedge clk) disable iff (!rst_n)
    code_start_displacement[CODE_AREA_START_BITS_LO-1:0] == '0
    && code_start_displacement[WORD_W-1 -: CODE_AREA_START_BITS_HI] == '0)
    else $error("code start fixed bits not zero");
  a_alias_equal: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && reg_index == IDX_PROT_ALIAS) |=> reg_rdata == protection_word_copy)
    else $error("protection alias differs from primary");
  a_ro_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (cap_done && reg_wr && reg_index == IDX_FUNC) |=> $stable(function_word_copy))
    else $error("write altered function word copy");

  c_program_done: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(program_pulse) ##[1:300] !flash_busy_flag);
  c_module_erase: cover property (@(posedge clk) disable iff (!rst_n) $rose(module_erase_pulse));
  c_access: cover property (@(posedge clk) disable iff (!rst_n) access_grant);
  c_alias_read: cover property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_index == IDX_PROT_ALIAS);

endmodule : flash_timing_and_autoread_regs

// File: cpu_master.sv
// cpu bus master model for the flash timing register port
`timescale 1ns/1ps
module cpu_master (
  // clock
  input  logic                                clk,
  // register port
  output logic [flash_timing_pkg::IDX_W-1:0]  reg_index,
  output logic                                reg_wr,
  output logic                                reg_rd,
  output logic [flash_timing_pkg::WORD_W-1:0] reg_wdata,
  input  logic [flash_timing_pkg::WORD_W-1:0] reg_rdata,
  // status
  input  logic                                flash_busy_flag
);
  import flash_timing_pkg::*;

  initial begin
    reg_index = 4'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end

  task automatic write_reg(input logic [3:0] idx, input logic [15:0] d);
    while (flash_busy_flag === 1'b1) @(posedge clk);
    @(posedge clk);
    reg_index <= idx;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    // stale data would hide a late capture, so show its inverse
    reg_wdata <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] idx, output logic [15:0] d);
    @(posedge clk);
    reg_index <= idx;
    reg_rd    <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : read_reg

endmodule : cpu_master

// File: tb_top.sv
// self-checking bench for the flash timing and auto-read registers
`timescale 1ns/1ps
module tb_top;
  import flash_timing_pkg::*;
  localparam int TIMEOUT = 40000;

  logic              clk        = 1'b0;
  logic              rstn       = 1'b0;
  logic              op_start   = 1'b0;
  op_t               op_kind    = OP_NONE;
  logic              access_req = 1'b0;
  logic [DIV_W-1:0]  div        = 5'h00;
  logic [WORD_W-1:0] fword;
  logic [WORD_W-1:0] pword;
  logic [IDX_W-1:0]  reg_index;
  logic              reg_wr;
  logic              reg_rd;
  logic [15:0]       reg_wdata;
  logic [15:0]       reg_rdata;
  logic [15:0]       cdisp;
  logic              busy;
  logic              p_pg;
  logic              p_pe;
  logic              p_me;
  logic              grant;
  logic [15:0]       seed       = 16'h5E8C;
  logic [15:0]       v;
  logic [7:0]        rst_tab [6] = '{8'h16, 8'h04, 8'hEA, 8'h18, 8'h3C, 8'h04};
  int                n_fail     = 0;
  int                checks_done = 0;
  int                cycles     = 0;
  int                p, e, d, m, r;

  always #10 clk = ~clk;

  cpu_master i_cpu (.clk(clk), .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flash_busy_flag(busy));

  flash_timing_and_autoread_regs i_dut (.clk(clk), .rstn(rstn), .reg_index(reg_index),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .op_start(op_start), .op_kind(op_kind), .access_req(access_req),
    .prescale_divisor(div), .info_function_word(fword), .info_protection_word(pword),
    .flash_busy_flag(busy), .program_pulse(p_pg), .page_erase_pulse(p_pe),
    .module_erase_pulse(p_me), .access_grant(grant), .code_start_displacement(cdisp));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic int span(input int mult, input int val, input int dv);
    return mult * (val + 1) * (dv + 1);
  endfunction : span

  function automatic logic [15:0] code_exp(input logic [15:0] w);
    return {3'h0, ~w[3:0], 9'h000};
  endfunction : code_exp

  task automatic roll();
    seed = lfsr_next(seed);
  endtask : roll

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // the divisor must not move inside a phase: let any recovery run out first
  task automatic set_div(input int dv);
    repeat (1030) @(posedge clk);
    div <= 5'(dv);
  endtask : set_div

  task automatic run_op(input op_t k, input logic [2:0] hot, input int ep, input int eb);
    int n, np, nb;
    n = 0;
    np = 0;
    nb = 0;
    @(posedge clk);
    op_start <= 1'b1;
    op_kind  <= k;
    @(negedge clk);
    while (busy !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check("pulse select", {29'h0, hot}, {29'h0, p_pg, p_pe, p_me});
    while (busy === 1'b1 && nb < 20000) begin
      if ((p_pg | p_pe | p_me) === 1'b1) np++;
      nb++;
      @(posedge clk);
      op_start <= 1'b0;
      @(negedge clk);
    end
    check("pulse length", ep, np);
    check("busy length", eb, nb);
  endtask : run_op

  task automatic run_access(input int rc);
    int n, g;
    n = 0;
    g = 0;
    @(posedge clk);
    access_req <= 1'b1;
    @(negedge clk);
    while (grant !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    while (grant !== 1'b1 && g < 2000) begin
      @(negedge clk);
      g++;
    end
    @(posedge clk);
    access_req <= 1'b0;
    check("grant spacing", rc, g);
  endtask : run_access

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    roll();
    fword = seed;
    roll();
    pword = seed;
    for (int pass = 0; pass < 2; pass++) begin
      // second pass resets mid-run with a cleared boot region
      if (pass == 1) begin
        roll();
        fword = seed;
        pword = {seed[15:4], 4'h0};
        @(posedge clk);
        rstn <= 1'b0;
        div  <= 5'h00;
      end
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      for (int i = 0; i < 6; i++) begin
        i_cpu.read_reg(4'(i), v);
        check("reload reset", {24'h0, rst_tab[i]}, v);
      end
      i_cpu.write_reg(IDX_FUNC, ~fword);
      i_cpu.write_reg(IDX_PROT, ~pword);
      i_cpu.write_reg(IDX_CODE, 16'hFFFF);
      i_cpu.read_reg(IDX_FUNC, v);
      check("function word", fword, v);
      i_cpu.read_reg(IDX_PROT, v);
      check("protection word", pword, v);
      i_cpu.read_reg(IDX_PROT_ALIAS, v);
      check("protection alias", pword, v);
      i_cpu.read_reg(IDX_CODE, v);
      check("code start read", code_exp(pword), v);
      check("code start port", code_exp(pword), cdisp);
      i_cpu.read_reg(4'hF, v);
      check("unmapped read", 32'h0, v);
      run_op(OP_PROG, 3'b100, span(8, 'h16, 0), span(8, 'h16, 0) + 'h19);
      for (int i = 0; i < 6; i++) begin
        roll();
        i_cpu.write_reg(4'(i), seed);
        i_cpu.read_reg(4'(i), v);
        check("reload readback", {24'h0, seed[7:0]}, v);
      end
      roll();
      p = seed[2:0];
      e = seed[5:3];
      d = seed[7:6];
      i_cpu.write_reg(IDX_PROG, 16'(p));
      i_cpu.write_reg(IDX_END, 16'(e));
      set_div(d);
      run_op(OP_PROG, 3'b100, span(8, p, d), span(8, p, d) + span(1, e, d));
      set_div(0);
      i_cpu.write_reg(IDX_PERASE, 16'h0000);
      run_op(OP_PERASE, 3'b010, 4096, 4096 + e + 1);
      m = seed[10:8];
      i_cpu.write_reg(IDX_MERASE, 16'h0000);
      i_cpu.write_reg(IDX_MEND, 16'(m));
      run_op(OP_MERASE, 3'b001, 4096, 4096 + span(8, m, 0));
      roll();
      r = seed[2:0];
      d = seed[4:3];
      set_div(d);
      i_cpu.write_reg(IDX_RCV, 16'(r));
      run_access(span(1, r, d));
      set_div(0);
      op_start <= 1'b1;
      op_kind  <= OP_NONE;
      repeat (40) @(posedge clk);
      op_start <= 1'b0;
      @(negedge clk);
      check("no-op refused", 32'h0, {31'h0, busy});
    end
    complete_run();
  end

endmodule : tb_top
